// file: sdc_pkg.sv
// Package: command codes, beat carrier and timing counts of the SDRAM core.
// Assumes one 125 MHz clock domain and a command bus sampled on its rising edge.
package sdc_pkg;
	// ==========================================================
	// Geometry
	localparam int CLK_MHZ   = 125;
	localparam int BANKS     = 4;
	localparam int BANK_BITS = 2;
	localparam int ROW_BITS  = 12;
	localparam int COL_BITS  = 8;
	localparam int DATA_BITS = 32;
	localparam int LANES     = 4;
	localparam int ADDR_BITS = BANK_BITS + ROW_BITS + COL_BITS;
	localparam int AP_BIT    = 10;

	// ==========================================================
	// Mode word fields
	localparam int          MODE_BL_LSB = 0;
	localparam int          MODE_CL_LSB = 4;
	localparam logic [11:0] MODE_RESET  = 12'h020;
	localparam logic [2:0]  BL_FULL     = 3'h7;

	// ==========================================================
	// Cycle counts, power-up time in microseconds and start-up refresh count
	localparam int column_to_column_gap   = 1;
	localparam int clock_gate_entry_delay = 1;
	localparam int clock_gate_exit_delay  = 1;
	localparam int write_mask_latency     = 0;
	localparam int read_mask_latency      = 2;
	localparam int write_data_delay       = 0;
	localparam int write_to_activate_gap1 = 3;
	localparam int write_to_activate_gap2 = 4;
	localparam int write_to_activate_gap3 = 5;
	localparam int write_to_close_gap     = 3;
	localparam int write_to_stop_gap      = 1;
	localparam int write_to_column_gap    = 1;
	localparam int write_to_burst_close_gap = 2;
	localparam int mode_load_gap          = 2;
	localparam int MAX_READ_LATENCY       = 3;
	localparam int POWERUP_US             = 100;
	localparam int POWERUP_CYC            = POWERUP_US * CLK_MHZ;
	localparam int INIT_REFRESHES         = 2;

	// ==========================================================
	// Commands as {select, row strobe, column strobe, write enable}
	typedef enum logic [3:0] {
		CMD_LOAD_MODE = 4'h0,
		CMD_REFRESH   = 4'h1,
		CMD_PRECHARGE = 4'h2,
		CMD_ACTIVATE  = 4'h3,
		CMD_WRITE     = 4'h4,
		CMD_READ      = 4'h5,
		CMD_STOP      = 4'h6,
		CMD_NOP       = 4'h7,
		CMD_INHIBIT   = 4'h8
	} sdc_cmd_t;

	typedef enum logic [1:0] {
		BURST_IDLE  = 2'h0,
		BURST_READ  = 2'h1,
		BURST_WRITE = 2'h2
	} sdc_burst_t;

	typedef struct packed {
		logic [BANK_BITS-1:0] bank;
		logic [ROW_BITS-1:0]  row;
		logic [COL_BITS-1:0]  col;
		logic [DATA_BITS-1:0] data;
		logic [LANES-1:0]     mask;
	} sdc_beat_t;
endpackage

// file: sdc_fifo.sv
// Small first-in first-out buffer with valid and ready on both sides.
// Assumes one clock; DEPTH is a power of two.
`timescale 1ns/1ps
module sdc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input  wire logic             i_clock,
	input  wire logic             i_reset_n,
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_out_valid,
	input  wire logic             i_out_ready,
	output logic [WIDTH-1:0]      o_out_data
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("sdc_fifo depth must be a power of two of at least 2");
	end

	// ==========================================================
	// Pointers and count
	logic [WIDTH-1:0] store [DEPTH];
	logic [AW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
	logic [AW:0]      cnt_reg, cnt_next;
	logic             push, pop;

	always_comb begin
		push     = i_in_valid & o_in_ready;
		pop      = o_out_valid & i_out_ready;
		wr_next  = push ? AW'(wr_reg + 1'b1) : wr_reg;
		rd_next  = pop ? AW'(rd_reg + 1'b1) : rd_reg;
		cnt_next = cnt_reg;
		if (push && !pop) begin
			cnt_next = (AW+1)'(cnt_reg + 1'b1);
		end else if (pop && !push) begin
			cnt_next = (AW+1)'(cnt_reg - 1'b1);
		end
	end

	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			wr_reg  <= '0;
			rd_reg  <= '0;
			cnt_reg <= '0;
		end else begin
			wr_reg  <= wr_next;
			rd_reg  <= rd_next;
			cnt_reg <= cnt_next;
		end
	end

	// Storage carries no reset; count guards every read
	always_ff @(posedge i_clock) begin
		if (push) begin
			store[wr_reg] <= i_in_data;
		end
	end

	assign o_in_ready  = (cnt_reg != (AW+1)'(DEPTH));
	assign o_out_valid = (cnt_reg != '0);
	assign o_out_data  = store[rd_reg];
endmodule

// file: sdc_banks.sv
// Open or idle flag and open row of every bank.
// Assumes activate and close requests come already decoded, one clock.
`timescale 1ns/1ps
module sdc_banks #(
	parameter int BANKS     = 4,
	parameter int BANK_BITS = 2,
	parameter int ROW_BITS  = 12
) (
	input  wire logic                      i_clock,
	input  wire logic                      i_reset_n,
	input  wire logic                      i_activate,
	input  wire logic [BANK_BITS-1:0]      i_bank,
	input  wire logic [ROW_BITS-1:0]       i_row,
	input  wire logic [BANKS-1:0]          i_close,
	output logic [BANKS-1:0]               o_open,
	output logic [BANKS*ROW_BITS-1:0]      o_rows
);
	if (BANKS != (1 << BANK_BITS)) begin : g_bad_banks
		$error("sdc_banks bank count must match the select width");
	end

	// ==========================================================
	// One tracker per bank
	for (genvar g = 0; g < BANKS; g++) begin : g_bank
		logic                open_reg, open_next;
		logic [ROW_BITS-1:0] row_reg, row_next;
		logic                hit;

		always_comb begin
			hit       = i_activate && (i_bank == BANK_BITS'(g));
			open_next = open_reg;
			row_next  = row_reg;
			if (hit) begin
				open_next = 1'b1;
				row_next  = i_row;
			end else if (i_close[g]) begin
				open_next = 1'b0;
			end
		end

		always_ff @(posedge i_clock or negedge i_reset_n) begin
			if (!i_reset_n) begin
				open_reg <= 1'b0;
				row_reg  <= '0;
			end else begin
				open_reg <= open_next;
				row_reg  <= row_next;
			end
		end

		assign o_open[g]                         = open_reg;
		assign o_rows[g*ROW_BITS +: ROW_BITS]    = row_reg;
	end
endmodule

// file: sdc_core.sv
// SDRAM command decode, bursts, clock gate, refresh and the storage array.
// Assumes a controller on the pins that keeps the command spacing itself.
`timescale 1ns/1ps
module sdc_core #(
	parameter int POWERUP_CYCLES = sdc_pkg::POWERUP_CYC,
	parameter int WBUF_DEPTH     = 4
) (
	input  wire logic                          i_clock,
	input  wire logic                          i_reset_n,
	input  wire logic                          i_cke,
	input  wire logic                          i_cs_n,
	input  wire logic                          i_ras_n,
	input  wire logic                          i_cas_n,
	input  wire logic                          i_we_n,
	input  wire logic [sdc_pkg::BANK_BITS-1:0] i_ba,
	input  wire logic [11:0]                   i_addr,
	input  wire logic [sdc_pkg::LANES-1:0]     i_dqm,
	input  wire logic [sdc_pkg::DATA_BITS-1:0] i_dq,
	output logic [sdc_pkg::DATA_BITS-1:0]      o_dq,
	output logic [sdc_pkg::LANES-1:0]          o_dq_oe,
	output logic [sdc_pkg::BANKS-1:0]          o_bank_open,
	output logic [11:0]                        o_mode,
	output logic [sdc_pkg::ROW_BITS-1:0]       o_refresh_row,
	output logic                               o_self_refresh,
	output logic                               o_suspended,
	output logic                               o_init_done,
	output logic                               o_wbuf_ready
);
	localparam int PW = $clog2(POWERUP_CYCLES + 1);
	localparam int AB = sdc_pkg::ADDR_BITS;
	localparam int CB = sdc_pkg::COL_BITS;
	localparam int RB = sdc_pkg::ROW_BITS;
	localparam int LT = sdc_pkg::MAX_READ_LATENCY;
	localparam int MW = 1 << AB;

	if (POWERUP_CYCLES < 1 || WBUF_DEPTH < 2) begin : g_bad_param
		$error("sdc_core needs a power-up count of 1 and a buffer of 2");
	end

	// ==========================================================
	// Command decode
	sdc_pkg::sdc_cmd_t cmd;
	logic              active, take, is_col;

	always_comb begin
		cmd    = i_cs_n ? sdc_pkg::CMD_INHIBIT
			: sdc_pkg::sdc_cmd_t'({1'b0, i_ras_n, i_cas_n, i_we_n});
		take   = active & ~i_cs_n;
		is_col = take && (cmd == sdc_pkg::CMD_READ || cmd == sdc_pkg::CMD_WRITE);
	end

	// ==========================================================
	// Clock gate, self refresh, mode word, refresh row, start-up
	logic           suspended_reg, suspended_next, self_reg, self_next;
	logic [11:0]    mode_reg, mode_next;
	logic [RB-1:0]  ref_row_reg, ref_row_next;
	logic [PW-1:0]  pwr_reg, pwr_next;
	logic [1:0]     refs_reg, refs_next;
	logic           init_reg, init_next;
	logic [1:0]     read_lat;
	logic [CB-1:0]  bl_mask;

	always_comb begin
		active         = ~suspended_reg & ~self_reg;
		suspended_next = ~i_cke;
		self_next      = self_reg;
		mode_next      = mode_reg;
		ref_row_next   = ref_row_reg;
		pwr_next       = (pwr_reg != '0) ? PW'(pwr_reg - 1'b1) : pwr_reg;
		refs_next      = refs_reg;
		if (take && cmd == sdc_pkg::CMD_LOAD_MODE) begin
			mode_next = i_addr;
		end
		if (take && cmd == sdc_pkg::CMD_REFRESH) begin
			ref_row_next = RB'(ref_row_reg + 1'b1);
			if (!i_cke) begin
				self_next = 1'b1;
			end else if (pwr_reg == '0 && refs_reg != 2'(sdc_pkg::INIT_REFRESHES)) begin
				refs_next = 2'(refs_reg + 1'b1);
			end
		end
		if (self_reg && i_cke) begin
			self_next = 1'b0;
		end
		init_next = (refs_next == 2'(sdc_pkg::INIT_REFRESHES));
		case (mode_reg[sdc_pkg::MODE_CL_LSB +: 3])
			3'h1:    read_lat = 2'h1;
			3'h2:    read_lat = 2'h2;
			default: read_lat = 2'h3;
		endcase
		case (mode_reg[sdc_pkg::MODE_BL_LSB +: 3])
			3'h1:             bl_mask = 8'h01;
			3'h2:             bl_mask = 8'h03;
			3'h3:             bl_mask = 8'h07;
			sdc_pkg::BL_FULL: bl_mask = 8'hff;
			default:          bl_mask = 8'h00;
		endcase
	end

	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			suspended_reg <= 1'b0;
			self_reg      <= 1'b0;
			mode_reg      <= sdc_pkg::MODE_RESET;
			ref_row_reg   <= '0;
			pwr_reg       <= PW'(POWERUP_CYCLES);
			refs_reg      <= '0;
			init_reg      <= 1'b0;
		end else begin
			suspended_reg <= suspended_next;
			self_reg      <= self_next;
			mode_reg      <= mode_next;
			ref_row_reg   <= ref_row_next;
			pwr_reg       <= pwr_next;
			refs_reg      <= refs_next;
			init_reg      <= init_next;
		end
	end

	// ==========================================================
	// Burst engine; one beat per active clock
	sdc_pkg::sdc_burst_t        state_reg, state_next;
	logic [CB-1:0]              col_reg, col_next, left_reg, left_next, beat_col, rem;
	logic [sdc_pkg::BANK_BITS-1:0] bank_reg, bank_next, beat_bank;
	logic                       ap_reg, ap_next, beat, beat_wr, beat_ap, stop;
	logic [sdc_pkg::BANKS-1:0]  close_mask, bank_open;
	logic [sdc_pkg::BANKS*RB-1:0] rows;
	logic [RB-1:0]              beat_row;

	always_comb begin
		state_next = state_reg;
		col_next   = col_reg;
		bank_next  = bank_reg;
		left_next  = left_reg;
		ap_next    = ap_reg;
		beat       = 1'b0;
		beat_wr    = (state_reg == sdc_pkg::BURST_WRITE);
		beat_bank  = bank_reg;
		beat_col   = col_reg;
		beat_ap    = ap_reg;
		rem        = CB'(left_reg - 1'b1);
		close_mask = '0;
		// A close to the burst's bank or a stop truncates it at once
		stop = take && (cmd == sdc_pkg::CMD_STOP || (cmd == sdc_pkg::CMD_PRECHARGE
			&& (i_addr[sdc_pkg::AP_BIT] || i_ba == bank_reg)));
		if (take && cmd == sdc_pkg::CMD_PRECHARGE) begin
			close_mask = i_addr[sdc_pkg::AP_BIT] ? '1
				: sdc_pkg::BANKS'(1) << i_ba;
		end
		if (is_col) begin
			beat      = 1'b1;
			beat_wr   = (cmd == sdc_pkg::CMD_WRITE);
			beat_bank = i_ba;
			beat_col  = i_addr[CB-1:0];
			beat_ap   = i_addr[sdc_pkg::AP_BIT];
			rem       = bl_mask;
		end else if (active && state_reg != sdc_pkg::BURST_IDLE) begin
			if (stop) begin
				state_next = sdc_pkg::BURST_IDLE;
			end else begin
				beat = 1'b1;
			end
		end
		if (beat) begin
			col_next   = (beat_col & ~bl_mask) | (CB'(beat_col + 1'b1) & bl_mask);
			bank_next  = beat_bank;
			ap_next    = beat_ap;
			left_next  = rem;
			state_next = beat_wr ? sdc_pkg::BURST_WRITE : sdc_pkg::BURST_READ;
			if (rem == '0) begin
				state_next = sdc_pkg::BURST_IDLE;
				if (beat_ap) begin
					close_mask = close_mask | (sdc_pkg::BANKS'(1) << beat_bank);
				end
			end
		end
		beat_row = rows[beat_bank*RB +: RB];
	end

	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_reg <= sdc_pkg::BURST_IDLE;
			col_reg   <= '0;
			bank_reg  <= '0;
			left_reg  <= '0;
			ap_reg    <= 1'b0;
		end else begin
			state_reg <= state_next;
			col_reg   <= col_next;
			bank_reg  <= bank_next;
			left_reg  <= left_next;
			ap_reg    <= ap_next;
		end
	end

	sdc_banks #(
		.BANKS     (sdc_pkg::BANKS),
		.BANK_BITS (sdc_pkg::BANK_BITS),
		.ROW_BITS  (RB)
	) u_banks (
		.i_clock    (i_clock),
		.i_reset_n  (i_reset_n),
		.i_activate (take && cmd == sdc_pkg::CMD_ACTIVATE),
		.i_bank     (i_ba),
		.i_row      (i_addr[RB-1:0]),
		.i_close    (close_mask),
		.o_open     (bank_open),
		.o_rows     (rows)
	);

	// ==========================================================
	// Write path: beats queue here, drain stalls while the clock is gated
	sdc_pkg::sdc_beat_t wr_beat, drain_beat;
	logic               push, wbuf_ready, drain_valid;

	always_comb begin
		push    = beat & beat_wr;
		wr_beat = '{bank: beat_bank, row: beat_row, col: beat_col,
			data: i_dq, mask: i_dqm};
	end

	sdc_fifo #(
		.WIDTH ($bits(sdc_pkg::sdc_beat_t)),
		.DEPTH (WBUF_DEPTH)
	) u_wbuf (
		.i_clock     (i_clock),
		.i_reset_n   (i_reset_n),
		.i_in_valid  (push),
		.o_in_ready  (wbuf_ready),
		.i_in_data   (wr_beat),
		.o_out_valid (drain_valid),
		.i_out_ready (active),
		.o_out_data  (drain_beat)
	);

	// ==========================================================
	// Storage, one byte lane per array
	logic [LT-1:0]                 rp_valid_reg, rp_valid_next;
	logic [LT-1:0][AB-1:0]         rp_addr_reg, rp_addr_next;
	logic [1:0][sdc_pkg::LANES-1:0] dqm_reg, dqm_next;
	logic [sdc_pkg::DATA_BITS-1:0] rd_word, dq_next;
	logic [sdc_pkg::LANES-1:0]     oe_next;
	logic [1:0]                    sel;
	logic [AB-1:0]                 drain_addr;

	assign drain_addr = {drain_beat.bank, drain_beat.row, drain_beat.col};
	assign sel        = 2'(read_lat - 1'b1);

	for (genvar g = 0; g < sdc_pkg::LANES; g++) begin : g_lane
		logic [7:0] mem [MW];
		always_ff @(posedge i_clock) begin
			if (drain_valid && active && !drain_beat.mask[g]) begin
				mem[drain_addr] <= drain_beat.data[g*8 +: 8];
			end
		end
		assign rd_word[g*8 +: 8] = mem[rp_addr_reg[sel]];
	end

	// ==========================================================
	// Read pipeline; output stage picks the programmed latency
	always_comb begin
		rp_valid_next = rp_valid_reg;
		rp_addr_next  = rp_addr_reg;
		dqm_next      = dqm_reg;
		dq_next       = o_dq;
		oe_next       = o_dq_oe;
		if (active) begin
			rp_valid_next = {rp_valid_reg[LT-2:0], beat & ~beat_wr};
			rp_addr_next  = {rp_addr_reg[LT-2:0], {beat_bank, beat_row, beat_col}};
			dqm_next      = {dqm_reg[0], i_dqm};
			dq_next       = rd_word;
			oe_next       = rp_valid_reg[sel] ? ~dqm_reg[1] : '0;
		end
	end

	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rp_valid_reg   <= '0;
			rp_addr_reg    <= '0;
			dqm_reg        <= '0;
			o_dq           <= '0;
			o_dq_oe        <= '0;
			o_wbuf_ready   <= 1'b1;
		end else begin
			rp_valid_reg   <= rp_valid_next;
			rp_addr_reg    <= rp_addr_next;
			dqm_reg        <= dqm_next;
			o_dq           <= dq_next;
			o_dq_oe        <= oe_next;
			o_wbuf_ready   <= wbuf_ready;
		end
	end

	assign o_bank_open    = bank_open;
	assign o_mode         = mode_reg;
	assign o_refresh_row  = ref_row_reg;
	assign o_self_refresh = self_reg;
	assign o_suspended    = suspended_reg;
	assign o_init_done    = init_reg;

	// ==========================================================
	// Checks
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_reset_n);

	sequence s_read_stop;
		stop && state_reg == sdc_pkg::BURST_READ && read_lat == 2'h2;
	endsequence
	sequence s_two_live;
		active ##1 active;
	endsequence

	a_write_same_edge: assert property ((take && cmd == sdc_pkg::CMD_WRITE) |->
		(push && wr_beat.data == i_dq && wr_beat.mask == i_dqm))
		else $error("write word not taken with its command");
	a_gate_entry: assert property ((active && !i_cke) |=> !active)
		else $error("clock gate low did not suspend");
	a_gate_exit: assert property ((!active && i_cke) |=> active)
		else $error("clock gate high did not resume");
	a_read_mask: assert property (($past(active) && $past(active, 2) && $past(active, 3))
		|-> ((o_dq_oe & $past(i_dqm, 3)) == '0))
		else $error("masked read lane was driven");
	a_mode_load: assert property ((take && cmd == sdc_pkg::CMD_LOAD_MODE)
		|=> o_mode == $past(i_addr))
		else $error("mode word not stored");
	a_close_all: assert property ((take && cmd == sdc_pkg::CMD_PRECHARGE
		&& i_addr[sdc_pkg::AP_BIT]) |=> o_bank_open == '0)
		else $error("close of all banks left one open");
	a_deselect: assert property (i_cs_n |=> $stable(o_mode))
		else $error("deselected command changed state");
	a_read_cut: assert property (s_read_stop ##1 s_two_live |=> o_dq_oe == '0)
		else $error("read output not cut after close");
	a_refresh_row: assert property ((take && cmd == sdc_pkg::CMD_REFRESH)
		|=> o_refresh_row == RB'($past(o_refresh_row) + 1'b1))
		else $error("refresh row did not advance");
	a_column_each: assert property (is_col ##1 is_col
		|-> beat && (rp_valid_reg[0] || $past(push)))
		else $error("back to back column command lost");
endmodule

// file: sdc_ctrl_model.sv
// Controller model: drives the command pins, write data and the clock gate.
// Assumes the bench calls issue once a clock, just after each rising edge.
`timescale 1ns/1ps
module sdc_ctrl_model (
	input  wire logic        i_clock,
	input  wire logic [31:0] i_dev_dq,
	input  wire logic [3:0]  i_dev_oe,
	output logic             o_cke,
	output logic             o_cs_n,
	output logic             o_ras_n,
	output logic             o_cas_n,
	output logic             o_we_n,
	output logic [1:0]       o_ba,
	output logic [11:0]      o_addr,
	output logic [3:0]       o_dqm,
	output logic [31:0]      o_dq
);
	// ==========================================================
	// Pin drive
	logic        drv = 1'b0;
	logic [31:0] data = 32'h0;
	logic [31:0] last = 32'h0;
	initial begin
		o_cke = 1'b1;
		{o_cs_n, o_ras_n, o_cas_n, o_we_n} = 4'h8;
		o_ba = 2'h0;
		o_addr = 12'h0;
		o_dqm = 4'h0;
	end
	task automatic set_gate(input logic v);
		o_cke = v;
	endtask
	// One command a clock, held until the next edge takes it
	task automatic issue(input sdc_pkg::sdc_cmd_t c, input logic [1:0] ba,
		input logic [11:0] a, input logic dv, input logic [31:0] d, input logic [3:0] m);
		@(posedge i_clock);
		#1;
		{o_cs_n, o_ras_n, o_cas_n, o_we_n} = c;
		o_ba = ba;
		o_addr = a;
		o_dqm = m;
		drv = dv;
		data = d;
	endtask
	// ==========================================================
	// Wire resolution: an undriven lane never repeats its last value
	always @(posedge i_clock) begin
		last <= o_dq;
	end
	always_comb begin
		for (int l = 0; l < 4; l++) begin
			if (i_dev_oe[l]) begin
				o_dq[8*l +: 8] = i_dev_dq[8*l +: 8];
			end else if (drv) begin
				o_dq[8*l +: 8] = data[8*l +: 8];
			end else begin
				o_dq[8*l +: 8] = ~last[8*l +: 8];
			end
		end
	end
endmodule

// file: testbench.sv
// Self-checking bench for the SDRAM core with the controller model on its pins.
// Assumes a shortened power-up count of 8 clocks and one 125 MHz clock.
`timescale 1ns/1ps
module testbench;
	// ==========================================================
	// Signals
	logic        i_clock = 1'b0;
	logic        i_reset_n = 1'b0;
	int          fail_count = 0;
	int          samples_checked = 0;
	logic        cke, cs_n, ras_n, cas_n, we_n;
	logic [1:0]  ba;
	logic [11:0] addr, mode, rrow;
	logic [3:0]  dqm, oe, bopen;
	logic [31:0] dq_in, dq_out;
	logic        selfr, susp, initd, wrdy;
	always #4 i_clock = ~i_clock;

	sdc_ctrl_model u_sdc_ctrl_model (.i_clock(i_clock), .i_dev_dq(dq_out), .i_dev_oe(oe),
		.o_cke(cke), .o_cs_n(cs_n), .o_ras_n(ras_n), .o_cas_n(cas_n), .o_we_n(we_n),
		.o_ba(ba), .o_addr(addr), .o_dqm(dqm), .o_dq(dq_in));
	sdc_core #(.POWERUP_CYCLES(8)) u_sdc_core (.i_clock(i_clock),
		.i_reset_n(i_reset_n), .i_cke(cke), .i_cs_n(cs_n), .i_ras_n(ras_n),
		.i_cas_n(cas_n), .i_we_n(we_n), .i_ba(ba), .i_addr(addr), .i_dqm(dqm),
		.i_dq(dq_in), .o_dq(dq_out), .o_dq_oe(oe), .o_bank_open(bopen), .o_mode(mode),
		.o_refresh_row(rrow), .o_self_refresh(selfr), .o_suspended(susp),
		.o_init_done(initd), .o_wbuf_ready(wrdy));

	// ==========================================================
	// Helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic op(input sdc_pkg::sdc_cmd_t c, input logic [1:0] b, input logic [11:0] a,
		input logic dv, input logic [31:0] d, input logic [3:0] m);
		u_sdc_ctrl_model.issue(c, b, a, dv, d, m);
	endtask
	// Each call lets one more edge pass; n calls after a command land after edge n-1
	task automatic nops(input int n);
		repeat (n) op(sdc_pkg::CMD_NOP, 2'h0, 12'h0, 1'b0, 32'h0, 4'h0);
	endtask
	task automatic final_report();
		if (fail_count == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_start();
		chk(32'(mode), 32'h020);
		chk(32'({bopen, initd, wrdy, selfr}), 32'h02);
		nops(10);
		op(sdc_pkg::CMD_REFRESH, 2'h0, 12'h0, 1'b0, 32'h0, 4'h0);
		op(sdc_pkg::CMD_REFRESH, 2'h0, 12'h0, 1'b0, 32'h0, 4'h0);
		nops(2);
		chk(32'(initd), 32'h1);
		chk(32'(rrow), 32'h2);
		op(sdc_pkg::CMD_LOAD_MODE, 2'h3, 12'h021, 1'b0, 32'h0, 4'h0);
		nops(2);
		chk(32'(mode), 32'h021);
	endtask
	task automatic t_banks();
		op(sdc_pkg::CMD_ACTIVATE, 2'h0, 12'h123, 1'b0, 32'h0, 4'h0);
		op(sdc_pkg::CMD_ACTIVATE, 2'h3, 12'h456, 1'b0, 32'h0, 4'h0);
		op(sdc_pkg::sdc_cmd_t'(4'hb), 2'h1, 12'h0, 1'b0, 32'h0, 4'h0);
		nops(2);
		chk(32'(bopen), 32'h9);
	endtask
	task automatic t_write_read();
		op(sdc_pkg::CMD_WRITE, 2'h0, 12'h004, 1'b1, 32'h1234abcd, 4'h0);
		op(sdc_pkg::CMD_NOP, 2'h0, 12'h0, 1'b1, 32'h5a5a0f0f, 4'h0);
		nops(1);
		op(sdc_pkg::CMD_WRITE, 2'h0, 12'h004, 1'b1, 32'hffffffff, 4'he);
		op(sdc_pkg::CMD_NOP, 2'h0, 12'h0, 1'b1, 32'hffffffff, 4'hf);
		nops(2);
		op(sdc_pkg::CMD_READ, 2'h0, 12'h004, 1'b0, 32'h0, 4'h0);
		op(sdc_pkg::CMD_READ, 2'h0, 12'h004, 1'b0, 32'h0, 4'h3);
		nops(2);
		chk(dq_out, 32'h1234abff);
		chk(32'(oe), 32'hf);
		nops(1);
		chk(32'(oe), 32'hc);
		nops(1);
		chk(dq_out, 32'h5a5a0f0f);
		nops(1);
		chk(32'(oe), 32'h0);
	endtask
	task automatic t_close();
		op(sdc_pkg::CMD_READ, 2'h0, 12'h004, 1'b0, 32'h0, 4'h0);
		op(sdc_pkg::CMD_PRECHARGE, 2'h0, 12'h0, 1'b0, 32'h0, 4'h0);
		nops(2);
		chk(32'({oe, bopen}), 32'hf8);
		nops(1);
		chk(32'(oe), 32'h0);
		op(sdc_pkg::CMD_ACTIVATE, 2'h0, 12'h123, 1'b0, 32'h0, 4'h0);
		op(sdc_pkg::CMD_ACTIVATE, 2'h1, 12'h010, 1'b0, 32'h0, 4'h0);
		nops(1);
		op(sdc_pkg::CMD_READ, 2'h0, 12'h404, 1'b0, 32'h0, 4'h0);
		nops(4);
		chk(32'(bopen), 32'ha);
		op(sdc_pkg::CMD_PRECHARGE, 2'h3, 12'h0, 1'b0, 32'h0, 4'h0);
		nops(2);
		chk(32'(bopen), 32'h2);
		op(sdc_pkg::CMD_PRECHARGE, 2'h0, 12'h400, 1'b0, 32'h0, 4'h0);
		nops(2);
		chk(32'(bopen), 32'h0);
	endtask
	// Auto-close write, then a write cut by a stop one clock after its data
	task automatic t_stop();
		op(sdc_pkg::CMD_ACTIVATE, 2'h2, 12'h020, 1'b0, 32'h0, 4'h0);
		nops(1);
		op(sdc_pkg::CMD_WRITE, 2'h2, 12'h408, 1'b1, 32'hcafe0001, 4'h0);
		op(sdc_pkg::CMD_NOP, 2'h0, 12'h0, 1'b1, 32'hcafe0002, 4'h0);
		nops(4);
		chk(32'(bopen), 32'h0);
		op(sdc_pkg::CMD_ACTIVATE, 2'h2, 12'h020, 1'b0, 32'h0, 4'h0);
		nops(1);
		op(sdc_pkg::CMD_WRITE, 2'h2, 12'h010, 1'b1, 32'h0badf00d, 4'h0);
		op(sdc_pkg::CMD_NOP, 2'h0, 12'h0, 1'b1, 32'h600dcafe, 4'h0);
		nops(1);
		op(sdc_pkg::CMD_WRITE, 2'h2, 12'h010, 1'b1, 32'h11111111, 4'h0);
		op(sdc_pkg::CMD_STOP, 2'h0, 12'h0, 1'b1, 32'h22222222, 4'h0);
		op(sdc_pkg::CMD_READ, 2'h2, 12'h010, 1'b0, 32'h0, 4'h0);
		nops(3);
		chk(dq_out, 32'h11111111);
		nops(1);
		chk(dq_out, 32'h600dcafe);
		op(sdc_pkg::CMD_PRECHARGE, 2'h2, 12'h0, 1'b0, 32'h0, 4'h0);
		nops(2);
		chk(32'(bopen), 32'h0);
	endtask
	task automatic t_gate();
		u_sdc_ctrl_model.set_gate(1'b0);
		nops(1);
		op(sdc_pkg::CMD_ACTIVATE, 2'h2, 12'h0, 1'b0, 32'h0, 4'h0);
		chk(32'(susp), 32'h1);
		u_sdc_ctrl_model.set_gate(1'b1);
		nops(1);
		chk(32'(susp), 32'h0);
		nops(2);
		chk(32'(bopen), 32'h0);
		// Gate drops with the refresh itself, so the command is still taken
		op(sdc_pkg::CMD_REFRESH, 2'h0, 12'h0, 1'b0, 32'h0, 4'h0);
		u_sdc_ctrl_model.set_gate(1'b0);
		nops(1);
		chk(32'({selfr, rrow}), 32'h1003);
		u_sdc_ctrl_model.set_gate(1'b1);
		nops(3);
		chk(32'({selfr, wrdy}), 32'h1);
	endtask

	// ==========================================================
	// Sequence and watchdog
	initial begin
		repeat (4) @(posedge i_clock);
		#1 i_reset_n = 1'b1;
		t_start();
		t_banks();
		t_write_read();
		t_close();
		t_stop();
		t_gate();
		final_report();
	end
	// Whole run is under 100 clocks; this allows some twenty times that
	initial begin
		#16000;
		fail_count++;
		final_report();
	end
endmodule
